// >>> config_shifter.sv
`timescale 1ns/10ps
`include "sar_seq_defines.svh"
module config_shifter (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // sampling strobes
  input wire logic shift_in,
  input wire logic start_in,
  input wire logic bit_in,
  // assembled word
  output sar_seq_pkg::config_word_t word_out,
  output logic done_out,
  output logic active_out
);
  import sar_seq_pkg::*;

  config_word_t shift_r, shift_nxt;
  logic [3:0] count_r, count_nxt;
  logic active_r, active_nxt;
  logic done_r, done_nxt;

  always_comb begin
    shift_nxt = shift_r;
    count_nxt = count_r;
    active_nxt = active_r;
    done_nxt = 1'b0;
    if (shift_in && (active_r || start_in)) begin
      shift_nxt = {shift_r[10:0], bit_in}; // msb arrives first
      if (!active_r) begin
        active_nxt = 1'b1;
        count_nxt = 4'h1;
      end else if (count_r == `CFG_LAST_BIT) begin
        // word complete on its twelfth falling edge; clock may stop here
        active_nxt = 1'b0;
        count_nxt = 4'h0;
        done_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      shift_r <= `CFG_RESET_VAL;
      count_r <= 4'h0;
      active_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      count_r <= count_nxt;
      active_r <= active_nxt;
      done_r <= done_nxt;
    end
  end

  assign word_out = shift_r;
  assign done_out = done_r;
  assign active_out = active_r;
endmodule

// >>> conv_host.sv
`timescale 1ns/10ps
module conv_host (
  // clock
  input wire logic sys_clk_in,
  // host pins
  output logic conv_clk_out,
  output logic strobe_out,
  output logic rd_out,
  output logic sdi_out
);
  initial begin
    conv_clk_out = 1'b0;
    strobe_out = 1'b0;
    rd_out = 1'b0;
    sdi_out = 1'b0;
  end

  // read raised, with the strobe when cv is set, while the converter clock is parked low
  task automatic frame(input logic [11:0] w, input bit cv, input int n, input int half,
                       input bit extra);
    int i;
    @(posedge sys_clk_in);
    strobe_out <= cv;
    rd_out <= 1'b1;
    sdi_out <= w[11];
    for (i = 0; i < n; i++) begin
      repeat (half) @(posedge sys_clk_in);
      conv_clk_out <= 1'b1;
      // lines move on rises so every fall sees settled data
      if (i == 1) begin
        strobe_out <= 1'b0;
        rd_out <= 1'b0;
      end
      // spent data line toggles so no stale bit looks valid
      if (i > 0) sdi_out <= (i < 12) ? w[11 - i] : ~sdi_out;
      repeat (half) @(posedge sys_clk_in);
      conv_clk_out <= 1'b0;
      // deliberate strobe while busy, off the rise so only the strobe is new
      if (extra && i == 3) strobe_out <= 1'b1;
      if (i == 4) strobe_out <= 1'b0;
    end
    // clock then stands low until the next frame
    repeat (half) @(posedge sys_clk_in);
  endtask
endmodule

// >>> dual_sar_conversion_sequencer.sv
`timescale 1ns/10ps
`include "sar_seq_defines.svh"
// Functional notes
// - strobe rising edge puts both inputs into hold
// - conversion starts at next converter clock rise
// - both converters sample and convert together
// - read strobe sampled on converter clock fall
// - one conversion lasts twelve converter clocks
// - one precharge cycle, then reconnect multiplexer
// - clock may stop after sixteenth fall; state kept
// - clock may stop after fourteenth fall, DAC write
// - busy stays low during whole acquisition
// - full differential codes 00 and 11 pair inputs
// - pseudo differential codes 00/01/10 share negative
// - channel bits of config word select inputs
// - power-on reset restores default configuration
// - software reset through the action field
// - busy rises at hold, falls at conversion end
// - twelve-bit config word, msb first, channel top
// - action 101 resets, 001/011 arm DAC access
module dual_sar_conversion_sequencer (
  // system
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // host pins
  input wire logic conversion_clock_in,
  input wire logic conversion_start_strobe_in,
  input wire logic read_strobe_in,
  input wire logic serial_config_input_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // analog front-end control
  output logic sample_hold_out,
  output logic precharge_out,
  output logic busy_out,
  output logic [1:0] positive_select_out,
  output logic negative_select_out,
  output sar_seq_pkg::phase_t phase_out,
  output logic [3:0] sar_step_out,
  output logic dac_write_pending_out,
  output logic dac_read_pending_out
);
  import sar_seq_pkg::*;

  logic dclk_rise, dclk_fall;
  logic strobe_rise;
  logic read_level;
  logic serial_level;
  config_word_t frame_word;
  logic frame_done, frame_active;

  // host clock is just sampled, so duty cycle only needs each phase > 1 period
  pin_sync clock_sync (
    .clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pin_in(conversion_clock_in),
    .level_out(),
    .rise_out(dclk_rise),
    .fall_out(dclk_fall)
  );

  pin_sync strobe_sync (
    .clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pin_in(conversion_start_strobe_in),
    .level_out(),
    .rise_out(strobe_rise),
    .fall_out()
  );

  pin_sync read_sync (
    .clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pin_in(read_strobe_in),
    .level_out(read_level),
    .rise_out(),
    .fall_out()
  );

  pin_sync serial_sync (
    .clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pin_in(serial_config_input_in),
    .level_out(serial_level),
    .rise_out(),
    .fall_out()
  );

  config_shifter shifter (
    .clk_in(sys_clk_in),
    .reset_in(reset_in),
    .shift_in(dclk_fall),
    .start_in(read_level), // read strobe looked at only on falls
    .bit_in(serial_level),
    .word_out(frame_word),
    .done_out(frame_done),
    .active_out(frame_active)
  );

  // conversion sequencer
  phase_t phase_r, phase_nxt;
  logic [3:0] step_r, step_nxt;
  logic hold_r, hold_nxt;
  logic pre_r, pre_nxt;
  logic busy_r, busy_nxt;
  logic [15:0] count_r, count_nxt;

  always_comb begin
    phase_nxt = phase_r;
    step_nxt = step_r;
    hold_nxt = hold_r;
    pre_nxt = pre_r;
    busy_nxt = busy_r;
    count_nxt = count_r;
    // past acquisition nothing moves without host clock edges, so a stopped clock freezes state
    unique case (phase_r)
      ph_acquire: begin
        if (strobe_rise) begin
          phase_nxt = ph_hold_wait;
          hold_nxt = 1'b1; // one switch control for both converters
          busy_nxt = 1'b1;
        end
      end
      ph_hold_wait: begin
        // a rise coinciding with the strobe is not used; start waits for the next
        if (dclk_rise) begin
          phase_nxt = ph_convert;
          step_nxt = 4'h1;
        end
      end
      ph_convert: begin
        if (dclk_rise) begin
          if (step_r == `CONV_CYCLES) begin
            phase_nxt = ph_precharge;
            step_nxt = 4'h0;
            busy_nxt = 1'b0;
            pre_nxt = 1'b1;
            count_nxt = count_r + 16'h0001;
          end else begin
            step_nxt = step_r + 4'h1;
          end
        end
      end
      ph_precharge: begin
        if (dclk_rise) begin
          phase_nxt = ph_acquire; // reconnect after a single cycle
          pre_nxt = 1'b0;
          hold_nxt = 1'b0;
        end
      end
    endcase
    // strobes outside acquisition fall through unused
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_r <= ph_acquire;
      step_r <= 4'h0;
      hold_r <= 1'b0;
      pre_r <= 1'b0;
      busy_r <= 1'b0;
      count_r <= 16'h0000;
    end else begin
      phase_r <= phase_nxt;
      step_r <= step_nxt;
      hold_r <= hold_nxt;
      pre_r <= pre_nxt;
      busy_r <= busy_nxt;
      count_r <= count_nxt;
    end
  end

  // configuration word and DAC access
  config_word_t config_r, config_nxt;
  config_word_t dac_r, dac_nxt;
  logic dac_wr_r, dac_wr_nxt;
  logic dac_rd_r, dac_rd_nxt;
  logic [2:0] action;

  assign action = frame_word[`CFG_ACTION_HI:`CFG_ACTION_LO];

  always_comb begin
    config_nxt = config_r;
    dac_nxt = dac_r;
    dac_wr_nxt = dac_wr_r;
    dac_rd_nxt = dac_rd_r;
    if (frame_done) begin
      dac_wr_nxt = 1'b0;
      dac_rd_nxt = 1'b0;
      if (dac_wr_r) begin
        dac_nxt = frame_word; // armed frame carries DAC data
      end else if (dac_rd_r) begin
        config_nxt = config_r; // armed read frame leaves settings alone
      end else if (action == `ACTION_RESET) begin
        config_nxt = `CFG_RESET_VAL;
        dac_nxt = `DAC_RESET_VAL;
      end else begin
        config_nxt = frame_word;
        dac_wr_nxt = (action == `ACTION_DAC_WRITE);
        dac_rd_nxt = (action == `ACTION_DAC_READ);
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      config_r <= `CFG_RESET_VAL; // power-on default
      dac_r <= `DAC_RESET_VAL;
      dac_wr_r <= 1'b0;
      dac_rd_r <= 1'b0;
    end else begin
      config_r <= config_nxt;
      dac_r <= dac_nxt;
      dac_wr_r <= dac_wr_nxt;
      dac_rd_r <= dac_rd_nxt;
    end
  end

  // input multiplexer
  logic pseudo_r, pseudo_nxt;
  logic [1:0] pos_r, pos_nxt;
  logic neg_r, neg_nxt;
  logic [1:0] chan_code;

  assign chan_code = config_r[`CFG_CHSEL_HI:`CFG_CHSEL_LO];

  always_comb begin
    pos_nxt = pos_r;
    neg_nxt = neg_r;
    // only retarget while sampling so a held sample is never disturbed
    if (phase_r == ph_acquire) begin
      if (chan_code == `CODE_FIRST_PAIR) begin
        pos_nxt = `SEL_POS_FIRST;
      end else if (chan_code == `CODE_SECOND_NEG) begin
        pos_nxt = `SEL_POS_SECOND_NEG;
      end else begin
        pos_nxt = `SEL_POS_SECOND;
      end
      // pseudo mode keeps the first negative input as common mode for every code
      if (!pseudo_r && chan_code == `CODE_SECOND_PAIR) begin
        neg_nxt = `SEL_NEG_SECOND;
      end else begin
        neg_nxt = `SEL_NEG_FIRST;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pos_r <= `SEL_POS_FIRST;
      neg_r <= `SEL_NEG_FIRST;
    end else begin
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
    end
  end

  // wishbone slave
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic req;
  logic [31:0] rmux;

  assign req = wb_cyc_in & wb_stb_in & ~ack_r;

  always_comb begin
    rmux = 32'h00000000;
    unique case (wb_adr_in)
      `OFS_CTRL: rmux[`CTRL_PSEUDO_BIT] = pseudo_r;
      `OFS_STATUS: begin
        rmux[`STATUS_BUSY_BIT] = busy_r;
        rmux[`STATUS_HOLD_BIT] = hold_r;
        rmux[`STATUS_PRECHARGE_BIT] = pre_r;
        rmux[`STATUS_DAC_WR_BIT] = dac_wr_r;
        rmux[`STATUS_DAC_RD_BIT] = dac_rd_r;
        rmux[`STATUS_STEP_MSB:`STATUS_STEP_LSB] = step_r;
      end
      `OFS_CONFIG: rmux[11:0] = config_r;
      `OFS_CONV_COUNT: rmux[15:0] = count_r;
      `OFS_DAC_WORD: rmux[11:0] = dac_r;
      default: rmux = 32'h00000000;
    endcase
  end

  always_comb begin
    ack_nxt = req;
    rdata_nxt = rdata_r;
    pseudo_nxt = pseudo_r;
    if (req) begin
      rdata_nxt = wb_we_in ? 32'h00000000 : rmux;
      if (wb_we_in && wb_adr_in == `OFS_CTRL && wb_sel_in[0]) begin
        pseudo_nxt = wb_dat_in[`CTRL_PSEUDO_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
      pseudo_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      pseudo_r <= pseudo_nxt;
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdata_r;
  assign sample_hold_out = hold_r;
  assign precharge_out = pre_r;
  assign busy_out = busy_r;
  assign positive_select_out = pos_r;
  assign negative_select_out = neg_r;
  assign phase_out = phase_r;
  assign sar_step_out = step_r;
  assign dac_write_pending_out = dac_wr_r;
  assign dac_read_pending_out = dac_rd_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence start_seen_s;
    phase_r == ph_acquire && strobe_rise;
  endsequence
  sequence hold_entered_s;
    hold_r && busy_r && phase_r == ph_hold_wait;
  endsequence

  hold_on_strobe_a: assert property (start_seen_s |=> hold_entered_s)
    else $error("strobe did not enter hold with busy");
  conversion_begin_a: assert property (
    phase_r == ph_hold_wait && dclk_rise |=> phase_r == ph_convert && step_r == 4'h1)
    else $error("conversion did not begin at clock rise");
  twelve_cycles_a: assert property (
    phase_r == ph_convert && dclk_rise && step_r == 4'hc
    |=> phase_r == ph_precharge && !busy_r && pre_r)
    else $error("conversion did not end after twelve cycles");
  precharge_single_a: assert property (
    phase_r == ph_precharge && dclk_rise |=> !pre_r && !hold_r && phase_r == ph_acquire)
    else $error("precharge did not end after one cycle");
  acquire_busy_a: assert property (phase_r == ph_acquire |-> !busy_r && !hold_r)
    else $error("busy high during acquisition");
  busy_tracks_hold_a: assert property ($rose(hold_r) |-> $rose(busy_r))
    else $error("busy did not rise with hold");
  busy_strobe_ignored_a: assert property (
    busy_r && strobe_rise && !dclk_rise |=> $stable(step_r) && $stable(phase_r))
    else $error("strobe disturbed running conversion");
  soft_reset_a: assert property (
    frame_done && !dac_wr_r && !dac_rd_r && action == 3'h5 |=> config_r == 12'h000)
    else $error("reset action did not clear configuration");
  second_pair_a: assert property (
    phase_r == ph_acquire && !pseudo_r && chan_code == 2'h3 |=> pos_r == 2'h2 && neg_r)
    else $error("second pair not routed");
  pseudo_common_a: assert property (
    phase_r == ph_acquire && pseudo_r |=> !neg_r)
    else $error("pseudo mode lost common negative input");
  bus_answer_a: assert property (req |=> ack_r ##1 !ack_r)
    else $error("wishbone ack not one cycle");
endmodule

// >>> pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // asynchronous pin
  input wire logic pin_in,
  // synchronised level and edges
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_r, meta_nxt;
  logic level_r, level_nxt;
  logic prev_r, prev_nxt;

  always_comb begin
    meta_nxt = pin_in;
    level_nxt = meta_r;
    prev_nxt = level_r;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_r <= 1'b0;
      level_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      level_r <= level_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign level_out = level_r;
  assign rise_out = level_r & ~prev_r;
  assign fall_out = ~level_r & prev_r;
endmodule

// >>> sar_seq_defines.svh
`ifndef SAR_SEQ_DEFINES_SVH
`define SAR_SEQ_DEFINES_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_CONFIG 8'h08
`define OFS_CONV_COUNT 8'h0c
`define OFS_DAC_WORD 8'h10

// control and status fields
`define CTRL_PSEUDO_BIT 0
`define STATUS_BUSY_BIT 0
`define STATUS_HOLD_BIT 1
`define STATUS_PRECHARGE_BIT 2
`define STATUS_DAC_WR_BIT 3
`define STATUS_DAC_RD_BIT 4
`define STATUS_STEP_LSB 8
`define STATUS_STEP_MSB 11

// serial configuration word
`define CFG_LAST_BIT 4'hb
`define CFG_RESET_VAL 12'h000
`define DAC_RESET_VAL 12'h3ff
`define CFG_CHSEL_HI 11
`define CFG_CHSEL_LO 10
`define CFG_ACTION_HI 2
`define CFG_ACTION_LO 0
`define ACTION_DAC_WRITE 3'h1
`define ACTION_DAC_READ 3'h3
`define ACTION_RESET 3'h5

// channel codes and multiplexer selections
`define CODE_FIRST_PAIR 2'h0
`define CODE_SECOND_NEG 2'h1
`define CODE_SECOND_PAIR 2'h3
`define SEL_POS_FIRST 2'h0
`define SEL_POS_SECOND_NEG 2'h1
`define SEL_POS_SECOND 2'h2
`define SEL_NEG_FIRST 1'h0
`define SEL_NEG_SECOND 1'h1

// conversion timing in converter clock cycles
`define CONV_CYCLES 4'hc

`endif

// >>> sar_seq_pkg.sv
package sar_seq_pkg;

  typedef enum logic [1:0] {
    ph_acquire,
    ph_hold_wait,
    ph_convert,
    ph_precharge
  } phase_t;

  typedef logic [11:0] config_word_t;

endpackage

// >>> tb.sv
`timescale 1ns/10ps
module tb;
  import sar_seq_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic conv_clk, strobe, rd, serial_config_input;
  logic [31:0] rdat;
  logic ack, hold, pre, busy, nsel;
  logic [1:0] psel;
  phase_t ph;
  logic [3:0] step;
  logic [3:0] step_q = 4'h0;
  logic busy_q = 1'b0;
  logic hold_q = 1'b0;
  logic [2:0] na [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
  logic [31:0] exp_q [$];
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int seed = 32'ha3e6;

  conv_host host (.sys_clk_in(sys_clk), .conv_clk_out(conv_clk), .strobe_out(strobe),
    .rd_out(rd), .sdi_out(serial_config_input));

  dual_sar_conversion_sequencer uut (.sys_clk_in(sys_clk), .reset_in(reset_in),
    .conversion_clock_in(conv_clk), .conversion_start_strobe_in(strobe),
    .read_strobe_in(rd), .serial_config_input_in(serial_config_input), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .sample_hold_out(hold), .precharge_out(pre), .busy_out(busy),
    .positive_select_out(psel), .negative_select_out(nsel), .phase_out(ph),
    .sar_step_out(step), .dac_write_pending_out(), .dac_read_pending_out());

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      mismatches++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // classic single cycle; the expected read word is queued for the monitor
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    int k;
    exp_q.push_back(e);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k == 50) chk(1'b0, "no acknowledge");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // watcher samples mid-cycle, clear of the launching edge
  always @(negedge sys_clk) begin
    if (ack) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected acknowledge");
      else chk(rdat === exp_q.pop_front(), "read data");
    end
    if (hold && !hold_q) chk(busy === 1'b1 && ph === ph_hold_wait, "hold start");
    if (!busy && busy_q) chk(pre === 1'b1 && ph === ph_precharge && step_q === 4'hc,
      "conversion end");
    if (step != step_q && step != 4'h0) chk(step === step_q + 4'h1, "step order");
    if (ph == ph_acquire && busy !== 1'b0) chk(1'b0, "busy in acquisition");
    busy_q <= busy;
    hold_q <= hold;
    step_q <= step;
  end

  initial begin
    logic [11:0] w;
    logic [31:0] r;
    int c, m, cnt;
    cnt = 0;
    repeat (6) @(posedge sys_clk);
    reset_in <= 1'b0;
    for (c = 0; c < 6; c++) wb(1'b0, 8'(c * 4), 32'h0, (c == 4) ? 32'h3ff : 32'h0);
    wb(1'b1, 8'h04, 32'hffffffff, 32'h0);
    wb(1'b0, 8'h04, 32'h0, 32'h0);
    for (m = 0; m < 2; m++) begin
      wb(1'b1, 8'h00, 32'(m), 32'h0);
      for (c = 0; c < 4; c++) begin
        r = $random(seed);
        w = {c[1:0], r[6:0], na[r[9:7] % 5]};
        host.frame(w, 1'b1, 16, (c == 1) ? 5 : 3, c == 2);
        cnt++;
        wb(1'b0, 8'h08, 32'h0, {20'h0, w});
        wb(1'b0, 8'h0c, 32'h0, 32'(cnt));
        chk(psel === ((c == 3) ? 2'h2 : c[1:0]) && nsel === (m == 0 && c == 3),
          "mux select");
      end
    end
    // control write with sel[0] clear must leave pseudo mode set
    sel <= 4'he;
    wb(1'b1, 8'h00, 32'h0, 32'h0);
    sel <= 4'hf;
    wb(1'b0, 8'h00, 32'h0, 32'h1);
    host.frame(12'h001, 1'b1, 16, 3, 1'b0);
    wb(1'b0, 8'h04, 32'h0, 32'h8);
    host.frame(12'h5a3, 1'b0, 14, 3, 1'b0);
    wb(1'b0, 8'h10, 32'h0, 32'h5a3);
    wb(1'b0, 8'h04, 32'h0, 32'h0);
    host.frame(12'h003, 1'b1, 16, 3, 1'b0);
    wb(1'b0, 8'h04, 32'h0, 32'h10);
    host.frame(12'h777, 1'b1, 16, 3, 1'b0);
    wb(1'b0, 8'h04, 32'h0, 32'h0);
    wb(1'b0, 8'h10, 32'h0, 32'h5a3);
    host.frame(12'hc05, 1'b1, 16, 3, 1'b0);
    repeat (40) @(posedge sys_clk);
    wb(1'b0, 8'h08, 32'h0, 32'h0);
    wb(1'b0, 8'h10, 32'h0, 32'h3ff);
    chk(psel === 2'h0 && nsel === 1'b0, "select after soft reset");
    @(posedge sys_clk);
    reset_in <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset_in <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(exp_q.size() == 0, "reads outstanding");
    tally_and_finish();
  end
endmodule
